// [design/rf_frame_buffer_pkg.sv]
// Constants, register map and state types for the frame buffer and address filter
//
// Operation
// R1: Mode zero buffered, other modes for test
// R2: Buffer transmit bytes, prepend preamble automatically
// R3: Host writes length byte first
// R4: RAM peek reads without removing bytes
// R5: Two start strobes; busy channel blocks one
// R6: Preamble after twelve symbols, data after SFD
// R7: Underflow flags, stops, sticky until flush
// R8: Transmit buffer holds one frame only
// R9: Sent frame stays for retransmission
// R10: Write after send flushes; underflow needs flush
// R11: Receive buffer holds several whole frames
// R12: Supervision pins follow receive buffer only
// R13: Serial mode bypasses buffers, 250 kHz clock
// R14: Serial transmit samples rising, persists until off
// R15: Serial receive clock idle until SFD
// R16: Beacons need source PAN match or accept
// R17: Destination PAN must match or broadcast
// R18: Destination address must match or broadcast
// R19: Source-only frames need coordinator and match
// R20: Failed frame flushed, earlier frames kept
// R21: Reserved types accepted when enabled, unchecked
// R22: After reject, skip rest before hunting
// R23: Length byte drives underflow detection
package rf_frame_buffer_pkg;

  // Register indices on the plain register port
  localparam logic [4:0] ADDR_CTRL_ZERO = 5'h00;
  localparam logic [4:0] ADDR_CTRL_ONE = 5'h01;
  localparam logic [4:0] ADDR_IO_ZERO = 5'h02;
  localparam logic [4:0] ADDR_SYNCWORD = 5'h03;
  localparam logic [4:0] ADDR_PAN_ID = 5'h04;
  localparam logic [4:0] ADDR_SHORT_ADDR = 5'h05;
  localparam logic [4:0] ADDR_EXT_ADDR0 = 5'h06;
  localparam logic [4:0] ADDR_STATUS = 5'h0a;
  localparam logic [4:0] ADDR_COMMAND = 5'h0b;
  localparam logic [4:0] ADDR_TX_QUEUE = 5'h0c;
  localparam logic [4:0] ADDR_RX_QUEUE = 5'h0d;
  localparam logic [4:0] ADDR_PEEK_PTR = 5'h0e;
  localparam logic [4:0] ADDR_PEEK_DATA = 5'h0f;

  // Field positions
  localparam int CTRL0_ADR_DECODE = 0;
  localparam int CTRL0_RESERVED_MODE = 1;
  localparam int CTRL0_COORDINATOR = 2;
  localparam int CTRL0_PREAMBLE_LSB = 4;
  localparam int CTRL1_TX_MODE_LSB = 0;
  localparam int CTRL1_RX_MODE_LSB = 2;
  localparam int IO0_BEACON_ACCEPT = 7;
  localparam int CMD_GO = 0;
  localparam int CMD_IF_CLEAR = 1;
  localparam int CMD_FLUSH = 2;
  localparam int CMD_OFF = 3;

  // Reset values
  localparam logic [15:0] CTRL0_RST = 16'h0041;
  localparam logic [15:0] CTRL1_RST = 16'h0000;
  localparam logic [15:0] IO0_RST = 16'h0040;
  localparam logic [15:0] SYNCWORD_RST = 16'ha70f;

  // Modes and frame types
  localparam logic [1:0] MODE_BUFFERED = 2'h0;
  localparam logic [1:0] MODE_SERIAL = 2'h1;
  localparam logic [2:0] FT_BEACON = 3'h0;
  localparam logic [2:0] FT_DATA = 3'h1;
  localparam logic [2:0] FT_COMMAND = 3'h3;
  localparam logic [15:0] PAN_BROADCAST = 16'hffff;
  localparam logic [7:0] QUEUE_DEPTH = 8'h80;

  // Timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int SYMBOL_NS = 16000;
  localparam int TX_START_SYMBOLS = 12;
  localparam int SYMBOL_CYCLES = SYMBOL_NS / CLK_PERIOD_NS;
  localparam int TX_START_CYCLES = TX_START_SYMBOLS * SYMBOL_CYCLES;
  localparam int SERIAL_CLK_KHZ = 250;
  localparam int SERIAL_HALF_CYCLES = (1000000 / CLK_PERIOD_NS) / (2 * SERIAL_CLK_KHZ);

  typedef enum logic [2:0] {TX_IDLE, TX_WAIT, TX_PRE, TX_SFD, TX_DATA, TX_SERIAL} txState_t;
  typedef enum logic [1:0] {RX_HUNT, RX_LEN, RX_BODY, RX_SKIP} rxState_t;

endpackage

// [design/rf_frame_buffer_addr_filter.sv]
// Transmit and receive frame queues, serial test mode and hardware address filter
`timescale 1ns/1ps
`default_nettype none
module rf_frame_buffer_addr_filter
  import rf_frame_buffer_pkg::*;
#(
  parameter int START_CYCLES = TX_START_CYCLES
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [4:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdData,
  input wire logic channelBusy,
  input wire logic modemByteReq,
  output logic [7:0] txByte,
  output logic txByteValid,
  output logic txUnderflowStatus,
  input wire logic [7:0] rxByte,
  input wire logic rxByteValid,
  input wire logic rxSfdFound,
  output logic queueHasData,
  output logic queueThresholdPin,
  input wire logic serialDataIn,
  output logic serialDataOut,
  output logic serialDataOe_n,
  output logic serialTxBit,
  output logic serialTxBitValid
);

  typedef struct packed {
    txState_t txState;
    logic [15:0] txWait;
    logic [7:0] txPtrW;
    logic [7:0] txPtrR;
    logic [6:0] txLen;
    logic txUnderflow;
    logic txDone;
    logic [3:0] txPreCnt;
    logic txSfdHigh;
    logic [7:0] txByte;
    logic txByteValid;
    rxState_t rxState;
    logic [7:0] rxWr;
    logic [7:0] rxRd;
    logic [7:0] rxStart;
    logic [6:0] rxLen;
    logic [6:0] rxIdx;
    logic [15:0] fcf;
    logic dpOk, dpBc;
    logic daOk, daBc;
    logic spOk;
    logic decided;
    logic serClk;
    logic [8:0] serDiv;
    logic [7:0] serShift;
    logic [3:0] serBits;
    logic sync1;
    logic sync2;
    logic serialOut;
    logic serialTxBit;
    logic serialTxBitValid;
    logic [15:0] ctrl0;
    logic [15:0] ctrl1;
    logic [15:0] io0;
    logic [15:0] syncWord;
    logic [15:0] panId;
    logic [15:0] shortAddr;
    logic [63:0] extAddr;
    logic [6:0] peek;
    logic [15:0] rdData;
    logic hasData;
    logic thresh;
  } state_t;

  state_t st, next_st;
  logic [7:0] txRam [128];
  logic [7:0] rxRam [128];
  logic txWe, rxWe;
  logic [6:0] txWAddr, rxWAddr;
  logic [7:0] txWData, rxWData;

  // Mode and field decode
  logic [1:0] txMode, rxMode, dm, sm;
  logic [2:0] ft;
  logic [7:0] rxCount, txNeed;
  logic [6:0] dpEnd, daEnd, spEnd, addrEnd, k;
  logic cmdWr, txQWr, flushCmd, goCmd, reject, accept, serRise, serFall, serActive;
  assign txMode = st.ctrl1[CTRL1_TX_MODE_LSB +: 2];
  assign rxMode = st.ctrl1[CTRL1_RX_MODE_LSB +: 2];
  assign dm = st.fcf[11:10];
  assign sm = st.fcf[15:14];
  assign ft = st.fcf[2:0];
  assign rxCount = st.rxWr - st.rxRd;
  assign cmdWr = regWr && (regAddr == ADDR_COMMAND);
  assign txQWr = regWr && (regAddr == ADDR_TX_QUEUE);
  assign flushCmd = cmdWr && regWrData[CMD_FLUSH];
  // Busy channel masks the conditional start strobe
  assign goCmd = cmdWr && (regWrData[CMD_GO] || (regWrData[CMD_IF_CLEAR] && !channelBusy)); // [R5]
  // Stored bytes that make a whole frame: length byte plus payload, FCS added later
  assign txNeed = (st.txLen < 7'd2) ? 8'h01 : {1'b0, st.txLen} - 8'h01; // [R23]
  // Address field boundaries, counted in MPDU bytes from the first FCF byte
  assign dpEnd = (dm != 2'h0) ? 7'd5 : 7'd3;
  assign daEnd = dpEnd + ((dm == 2'h2) ? 7'd2 : (dm == 2'h3) ? 7'd8 : 7'd0);
  assign spEnd = daEnd + ((sm != 2'h0 && !st.fcf[6]) ? 7'd2 : 7'd0);
  assign addrEnd = spEnd + ((sm == 2'h2) ? 7'd2 : (sm == 2'h3) ? 7'd8 : 7'd0);
  assign serActive = (st.txState == TX_SERIAL) ||
                     (rxMode == MODE_SERIAL && st.rxState inside {RX_LEN, RX_BODY});
  assign serRise = serActive && !st.serClk && (st.serDiv == 9'(SERIAL_HALF_CYCLES - 1));
  assign serFall = serActive && st.serClk && (st.serDiv == 9'(SERIAL_HALF_CYCLES - 1));

  // Filter verdict from the collected match flags
  always_comb begin
    accept = 1'b1;
    if (ft[2]) begin
      accept = st.ctrl0[CTRL0_RESERVED_MODE]; // [R21] [R20]
    end else begin
      if (ft == FT_BEACON && !(st.spOk || st.io0[IO0_BEACON_ACCEPT])) begin
        accept = 1'b0; // [R16]
      end
      if (dm != 2'h0 && !((st.dpOk || st.dpBc) && (st.daOk || (st.daBc && dm == 2'h2)))) begin
        accept = 1'b0; // [R17] [R18]
      end
      if (dm == 2'h0 && sm != 2'h0 && (ft == FT_DATA || ft == FT_COMMAND) &&
          !(st.ctrl0[CTRL0_COORDINATOR] && st.spOk)) begin
        accept = 1'b0; // [R19]
      end
    end
  end

  // Next-state logic for the whole block
  always_comb begin
    next_st = st;
    txWe = 1'b0;
    txWAddr = st.txPtrW[6:0];
    txWData = regWrData[7:0];
    rxWe = 1'b0;
    rxWAddr = st.rxWr[6:0];
    rxWData = rxByte;
    reject = 1'b0;
    k = st.rxIdx;
    next_st.txByteValid = 1'b0;
    next_st.serialTxBitValid = 1'b0;
    next_st.sync1 = serialDataIn;
    next_st.sync2 = st.sync1;
    // Configuration writes
    if (regWr) begin
      unique case (regAddr)
        ADDR_CTRL_ZERO: next_st.ctrl0 = regWrData;
        ADDR_CTRL_ONE: next_st.ctrl1 = regWrData; // [R1]
        ADDR_IO_ZERO: next_st.io0 = regWrData;
        ADDR_SYNCWORD: next_st.syncWord = regWrData;
        ADDR_PAN_ID: next_st.panId = regWrData;
        ADDR_SHORT_ADDR: next_st.shortAddr = regWrData;
        ADDR_PEEK_PTR: next_st.peek = regWrData[6:0];
        default: begin
          if (regAddr >= ADDR_EXT_ADDR0 && regAddr < ADDR_STATUS) begin
            next_st.extAddr[16 * (regAddr - ADDR_EXT_ADDR0) +: 16] = regWrData;
          end
        end
      endcase
    end
    // Host reads answer one cycle later; peek leaves the queue untouched
    next_st.rdData = 16'h0000;
    if (regRd) begin
      unique case (regAddr)
        ADDR_CTRL_ZERO: next_st.rdData = st.ctrl0;
        ADDR_CTRL_ONE: next_st.rdData = st.ctrl1;
        ADDR_IO_ZERO: next_st.rdData = st.io0;
        ADDR_SYNCWORD: next_st.rdData = st.syncWord;
        ADDR_PAN_ID: next_st.rdData = st.panId;
        ADDR_SHORT_ADDR: next_st.rdData = st.shortAddr;
        ADDR_STATUS: next_st.rdData = {rxCount, 4'h0, st.txDone,
                                       st.txState != TX_IDLE, 1'b0, st.txUnderflow};
        ADDR_PEEK_PTR: next_st.rdData = {9'h000, st.peek};
        ADDR_PEEK_DATA: next_st.rdData = {8'h00, txRam[st.peek]}; // [R4]
        ADDR_RX_QUEUE: begin
          if (rxCount != 8'h00) begin
            next_st.rdData = {8'h00, rxRam[st.rxRd[6:0]]};
            next_st.rxRd = st.rxRd + 8'h01;
          end
        end
        default: begin
          if (regAddr >= ADDR_EXT_ADDR0 && regAddr < ADDR_STATUS) begin
            next_st.rdData = st.extAddr[16 * (regAddr - ADDR_EXT_ADDR0) +: 16];
          end
        end
      endcase
    end
    // Host loads the transmit queue; the first byte is the frame length
    if (txQWr && !st.txUnderflow) begin // [R10]
      if (st.txDone) begin
        txWAddr = 7'h00; // [R10]
        txWe = 1'b1;
        next_st.txPtrW = 8'h01;
        next_st.txPtrR = 8'h00;
        next_st.txDone = 1'b0;
        next_st.txLen = regWrData[6:0]; // [R3]
      end else if (st.txPtrW == 8'h00) begin
        txWe = 1'b1;
        next_st.txPtrW = 8'h01;
        next_st.txLen = regWrData[6:0]; // [R3]
      end else if (st.txPtrW < txNeed && st.txPtrW < QUEUE_DEPTH) begin
        txWe = 1'b1; // [R8] [R2]
        next_st.txPtrW = st.txPtrW + 8'h01;
      end
    end
    // Transmit sequencer
    unique case (st.txState)
      TX_IDLE: begin
        if (goCmd) begin
          next_st.txState = TX_WAIT; // [R5]
          next_st.txWait = 16'(START_CYCLES - 1);
        end
      end
      TX_WAIT: begin
        next_st.txWait = st.txWait - 16'h0001;
        if (st.txWait == 16'h0000) begin
          next_st.txState = TX_PRE; // [R6]
          next_st.txPreCnt = st.ctrl0[CTRL0_PREAMBLE_LSB +: 4];
        end
      end
      TX_PRE: begin
        if (modemByteReq) begin
          next_st.txByte = 8'h00; // [R2]
          next_st.txByteValid = 1'b1;
          next_st.txPreCnt = st.txPreCnt - 4'h1;
          if (st.txPreCnt <= 4'h1) begin
            next_st.txState = TX_SFD;
            next_st.txSfdHigh = 1'b0;
          end
        end
      end
      TX_SFD: begin
        if (modemByteReq) begin
          next_st.txByte = st.txSfdHigh ? st.syncWord[15:8] : st.syncWord[7:0];
          next_st.txByteValid = 1'b1;
          next_st.txSfdHigh = 1'b1;
          if (st.txSfdHigh) begin
            next_st.txState = (txMode == MODE_SERIAL) ? TX_SERIAL : TX_DATA; // [R6] [R14]
          end
        end
      end
      TX_DATA: begin
        if (modemByteReq) begin
          if (st.txPtrR >= st.txPtrW) begin
            next_st.txUnderflow = 1'b1; // [R7] [R23]
            next_st.txState = TX_IDLE;
          end else begin
            next_st.txByte = txRam[st.txPtrR[6:0]];
            next_st.txByteValid = 1'b1;
            next_st.txPtrR = st.txPtrR + 8'h01;
            if (st.txPtrR + 8'h01 >= txNeed) begin
              next_st.txDone = 1'b1; // [R9]
              next_st.txPtrR = 8'h00;
              next_st.txState = TX_IDLE;
            end
          end
        end
      end
      TX_SERIAL: begin
        if (serRise) begin
          next_st.serialTxBit = st.sync2; // [R14]
          next_st.serialTxBitValid = 1'b1;
        end
        if (cmdWr && regWrData[CMD_OFF]) begin
          next_st.txState = TX_IDLE; // [R14]
        end
      end
      default: next_st.txState = TX_IDLE;
    endcase
    if (cmdWr && regWrData[CMD_OFF] && st.txState != TX_SERIAL) begin
      next_st.txState = TX_IDLE;
    end
    // Flush empties the queue and is the only clear of underflow
    if (flushCmd) begin
      next_st.txPtrW = 8'h00;
      next_st.txPtrR = 8'h00;
      next_st.txDone = 1'b0;
      next_st.txUnderflow = 1'b0; // [R7]
      next_st.txState = TX_IDLE;
    end
    // Receive framing and filtering
    unique case (st.rxState)
      RX_HUNT: begin
        if (rxSfdFound) begin
          next_st.rxState = RX_LEN;
          next_st.rxStart = st.rxWr;
        end
      end
      RX_LEN: begin
        if (rxByteValid) begin
          next_st.rxLen = rxByte[6:0];
          next_st.rxIdx = 7'h00;
          next_st.decided = (rxByte[6:0] == 7'h00);
          {next_st.dpOk, next_st.dpBc} = 2'b11;
          {next_st.daOk, next_st.daBc} = 2'b11;
          next_st.spOk = 1'b1;
          next_st.rxState = (rxByte[6:0] == 7'h00) ? RX_HUNT : RX_BODY;
          rxWe = (rxMode == MODE_BUFFERED); // [R11]
        end
      end
      RX_BODY: begin
        if (rxByteValid) begin
          rxWe = (rxMode == MODE_BUFFERED); // [R13]
          next_st.rxIdx = st.rxIdx + 7'h01;
          if (st.rxIdx == 7'h00) next_st.fcf[7:0] = rxByte;
          if (st.rxIdx == 7'h01) next_st.fcf[15:8] = rxByte;
          // Byte-wise comparison of address fields
          if (st.rxIdx >= 7'd3 && st.rxIdx < dpEnd) begin
            k = st.rxIdx - 7'd3;
            if (rxByte != st.panId[8 * k[0] +: 8]) next_st.dpOk = 1'b0; // [R17]
            if (rxByte != 8'hff) next_st.dpBc = 1'b0; // [R17]
          end else if (st.rxIdx >= dpEnd && st.rxIdx < daEnd) begin
            k = st.rxIdx - dpEnd;
            if (dm == 2'h2) begin
              if (rxByte != st.shortAddr[8 * k[0] +: 8]) next_st.daOk = 1'b0; // [R18]
              if (rxByte != 8'hff) next_st.daBc = 1'b0; // [R18]
            end else if (rxByte != st.extAddr[8 * k[2:0] +: 8]) begin
              next_st.daOk = 1'b0; // [R18]
            end
          end else if (st.rxIdx >= daEnd && st.rxIdx < spEnd) begin
            k = st.rxIdx - daEnd;
            if (rxByte != st.panId[8 * k[0] +: 8]) begin
              next_st.spOk = 1'b0; // [R16] [R19]
            end
          end
          if (st.rxIdx + 7'h01 == st.rxLen) begin
            next_st.rxState = RX_HUNT;
          end
        end
        // Verdict once the address fields or the frame are complete
        if (!st.decided && st.rxIdx >= 7'd2 &&
            (st.rxIdx >= addrEnd || st.rxState != next_st.rxState)) begin
          next_st.decided = 1'b1;
          if (st.ctrl0[CTRL0_ADR_DECODE] && rxMode == MODE_BUFFERED && !accept) begin
            reject = 1'b1;
          end
        end
        if (reject) begin
          rxWe = 1'b0;
          next_st.rxWr = st.rxStart; // [R20]
          next_st.rxState = (next_st.rxIdx == st.rxLen) ? RX_HUNT : RX_SKIP;
        end
      end
      RX_SKIP: begin
        if (rxByteValid) begin
          next_st.rxIdx = st.rxIdx + 7'h01;
          if (st.rxIdx + 7'h01 == st.rxLen) begin
            next_st.rxState = RX_HUNT; // [R22]
          end
        end
      end
    endcase
    if (rxWe) begin
      if (rxCount < QUEUE_DEPTH) begin
        next_st.rxWr = st.rxWr + 8'h01;
      end else begin
        rxWe = 1'b0;
      end
    end
    if (st.rxState == RX_BODY && next_st.rxState == RX_HUNT && !reject) begin
      next_st.rxStart = next_st.rxWr; // [R11]
    end
    // Serial clock: idle low until a frame is active
    if (serActive) begin
      next_st.serDiv = (st.serDiv == 9'(SERIAL_HALF_CYCLES - 1)) ? 9'h000 : st.serDiv + 9'h001;
      if (st.serDiv == 9'(SERIAL_HALF_CYCLES - 1)) next_st.serClk = !st.serClk; // [R13]
    end else begin
      next_st.serDiv = 9'h000;
      next_st.serClk = 1'b0; // [R15]
    end
    // Serial receive: bytes bypass the queue, bits change on the falling edge
    if (rxMode == MODE_SERIAL && rxByteValid && st.rxState inside {RX_LEN, RX_BODY}) begin
      next_st.serShift = rxByte; // [R13]
      next_st.serBits = 4'h8;
    end else if (serFall && st.serBits != 4'h0) begin
      next_st.serialOut = st.serShift[0];
      next_st.serShift = {1'b0, st.serShift[7:1]};
      next_st.serBits = st.serBits - 4'h1;
    end
    // Supervision pins reflect only the receive queue
    next_st.hasData = (next_st.rxWr != next_st.rxRd); // [R12]
    next_st.thresh = ((next_st.rxWr - next_st.rxRd) > {1'b0, st.io0[6:0]}); // [R12]
  end

  // State register and queue memories
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st <= '0;
      st.ctrl0 <= CTRL0_RST;
      st.ctrl1 <= CTRL1_RST;
      st.io0 <= IO0_RST;
      st.syncWord <= SYNCWORD_RST;
    end else begin
      st <= next_st;
    end
    if (txWe) txRam[txWAddr] <= txWData;
    if (rxWe) rxRam[rxWAddr] <= rxWData;
  end

  // Outputs straight from the state register; pins turn into clock and data in serial mode
  logic serialPins;
  assign serialPins = (txMode == MODE_SERIAL) || (rxMode == MODE_SERIAL);
  assign regRdData = st.rdData;
  assign txByte = st.txByte;
  assign txByteValid = st.txByteValid;
  assign txUnderflowStatus = st.txUnderflow; // [R7]
  assign queueHasData = serialPins ? st.serialOut : st.hasData;
  assign queueThresholdPin = serialPins ? st.serClk : st.thresh; // [R13]
  assign serialDataOut = st.serialOut;
  assign serialDataOe_n = !(rxMode == MODE_SERIAL && st.txState != TX_SERIAL);
  assign serialTxBit = st.serialTxBit;
  assign serialTxBitValid = st.serialTxBitValid;

  // Checks
  logic [15:0] waitCount;
  always_ff @(posedge core_clk) begin
    if (srst || st.txState != TX_WAIT) waitCount <= 16'h0000;
    else waitCount <= waitCount + 16'h0001;
  end
  property p_start_delay;
    @(posedge core_clk) disable iff (srst)
      (st.txState == TX_WAIT && next_st.txState == TX_PRE && !flushCmd)
        |-> waitCount == 16'(START_CYCLES - 1);
  endproperty
  a_start_delay: assert property (p_start_delay) else $error("preamble start delay wrong"); // [R6]
  property p_busy_ignored;
    @(posedge core_clk) disable iff (srst)
      (st.txState == TX_IDLE && cmdWr && regWrData == 16'h0002 && channelBusy)
        |=> st.txState == TX_IDLE;
  endproperty
  a_busy_ignored: assert property (p_busy_ignored) else $error("busy channel started tx"); // [R5]
  property p_underflow_sticky;
    @(posedge core_clk) disable iff (srst) (st.txUnderflow && !flushCmd) |=> st.txUnderflow;
  endproperty
  a_underflow_sticky: assert property (p_underflow_sticky) else $error("underflow lost"); // [R7]
  property p_flush_clears;
    @(posedge core_clk) disable iff (srst)
      flushCmd |=> !st.txUnderflow && st.txPtrW == 8'h00 && st.txState == TX_IDLE;
  endproperty
  a_flush_clears: assert property (p_flush_clears) else $error("flush incomplete"); // [R7]
  property p_refill;
    @(posedge core_clk) disable iff (srst)
      $rose(st.txDone) |-> st.txPtrR == 8'h00 && st.txPtrW == $past(st.txPtrW);
  endproperty
  a_refill: assert property (p_refill) else $error("frame not kept for resend"); // [R9]
  property p_write_after_done;
    @(posedge core_clk) disable iff (srst)
      (txQWr && st.txDone && !st.txUnderflow) |=> st.txPtrW == 8'h01 && !st.txDone;
  endproperty
  a_write_after_done: assert property (p_write_after_done) else $error("no auto flush"); // [R10]
  property p_no_write_underflow;
    @(posedge core_clk) disable iff (srst) (txQWr && st.txUnderflow) |=> $stable(st.txPtrW);
  endproperty
  a_no_write_underflow: assert property (p_no_write_underflow) else $error("write after underflow"); // [R10]
  property p_reject_rewind;
    @(posedge core_clk) disable iff (srst) reject |=> st.rxWr == $past(st.rxStart);
  endproperty
  a_reject_rewind: assert property (p_reject_rewind) else $error("rejected frame kept"); // [R20]
  property p_skip_no_hunt;
    @(posedge core_clk) disable iff (srst)
      (st.rxState == RX_SKIP && !rxByteValid) |=> st.rxState == RX_SKIP;
  endproperty
  a_skip_no_hunt: assert property (p_skip_no_hunt) else $error("hunt during skip"); // [R22]
  property p_serial_idle;
    @(posedge core_clk) disable iff (srst)
      (rxMode == MODE_SERIAL && st.txState != TX_SERIAL && st.rxState == RX_HUNT)[*2]
        |-> !queueThresholdPin;
  endproperty
  a_serial_idle: assert property (p_serial_idle) else $error("serial clock not idle"); // [R15]
  property p_pins_rx_only;
    @(posedge core_clk) disable iff (srst)
      (txMode == MODE_BUFFERED && rxMode == MODE_BUFFERED) |-> queueHasData == (rxCount != 8'h00);
  endproperty
  a_pins_rx_only: assert property (p_pins_rx_only) else $error("queue pin wrong"); // [R12]
  c_underflow: cover property (@(posedge core_clk) disable iff (srst) $rose(st.txUnderflow));
  c_tx_done: cover property (@(posedge core_clk) disable iff (srst) $rose(st.txDone));
  c_reject: cover property (@(posedge core_clk) disable iff (srst) reject);
  c_serial_tx: cover property (@(posedge core_clk) disable iff (srst) st.serialTxBitValid);

endmodule
`default_nettype wire

// [dv/host_master.sv]
// Host model that drives the register port of the frame buffer
`timescale 1ns/1ps
`default_nettype none
module host_master (
  input wire logic core_clk,
  output logic [4:0] regAddr,
  output logic [15:0] regWrData,
  output logic regWr,
  output logic regRd,
  input wire logic [15:0] regRdData
);
  // Bus idle from time zero
  initial begin
    regAddr = 5'h00;
    regWrData = 16'h0000;
    regWr = 1'b0;
    regRd = 1'b0;
  end

  // One-cycle write strobe beside address and data
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask

  // One-cycle read strobe, data taken in the following cycle
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1 d = regRdData;
  endtask
endmodule
`default_nettype wire

// [dv/test_rf_frame_buffer_addr_filter.sv]
// Testbench for the frame buffer and address filter
`timescale 1ns/1ps
`default_nettype none
module test_rf_frame_buffer_addr_filter;
  import rf_frame_buffer_pkg::*;
  localparam int SC = 20;
  logic core_clk, srst, channelBusy, modemByteReq, rxByteValid, rxSfdFound, serialDataIn;
  logic regWr, regRd, txByteValid, txUnderflowStatus, queueHasData, queueThresholdPin;
  logic serialDataOut, serialDataOe_n, serialTxBit, serialTxBitValid;
  logic [4:0] regAddr;
  logic [15:0] regWrData, regRdData, rd;
  logic [7:0] txByte, rxByte;
  logic [7:0] q[$], pl[$], rxq[$], fr[$];
  integer n_errors = 0;
  integer num_checks = 0;
  integer seed = 32'h26f1;
  // Free-running core clock
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  host_master i_host_master (.core_clk(core_clk), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData));
  rf_frame_buffer_addr_filter #(.START_CYCLES(SC)) i_rf_frame_buffer_addr_filter (
    .core_clk(core_clk), .srst(srst), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .channelBusy(channelBusy), .modemByteReq(modemByteReq),
    .txByte(txByte), .txByteValid(txByteValid), .txUnderflowStatus(txUnderflowStatus),
    .rxByte(rxByte), .rxByteValid(rxByteValid), .rxSfdFound(rxSfdFound),
    .queueHasData(queueHasData), .queueThresholdPin(queueThresholdPin),
    .serialDataIn(serialDataIn), .serialDataOut(serialDataOut), .serialDataOe_n(serialDataOe_n),
    .serialTxBit(serialTxBit), .serialTxBitValid(serialTxBitValid));
  // Compare one result against the model
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic give_verdict();
    $display("Checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Strobe a command, then wait out the start delay
  task automatic start(input int b);
    i_host_master.wr(ADDR_COMMAND, 16'h0001 << b);
    repeat (SC + 4) @(posedge core_clk);
  endtask
  // Modem pulls n bytes and compares each with the model queue
  task automatic fetch(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk) modemByteReq <= 1'b1;
      @(posedge core_clk) modemByteReq <= 1'b0;
      #1 chk("txByteValid", 16'h0001, {15'h0, txByteValid});
      chk("txByte", {8'h00, q[i]}, {8'h00, txByte});
    end
  endtask
  // Demodulator delivers one frame after its delimiter
  task automatic rx_frame();
    @(posedge core_clk) rxSfdFound <= 1'b1;
    @(posedge core_clk) rxSfdFound <= 1'b0;
    foreach (fr[i]) begin
      @(posedge core_clk) rxByteValid <= 1'b1;
      rxByte <= fr[i];
      @(posedge core_clk) rxByteValid <= 1'b0;
    end
    repeat (4) @(posedge core_clk);
  endtask
  // Hang guard
  initial begin
    #400000;
    n_errors++;
    give_verdict();
  end
  initial begin
    srst = 1'b1;
    channelBusy = 1'b0;
    modemByteReq = 1'b0;
    rxByte = 8'h00;
    rxByteValid = 1'b0;
    rxSfdFound = 1'b0;
    serialDataIn = 1'b1;
    repeat (10) @(posedge core_clk);
    srst <= 1'b0;
    i_host_master.rd(ADDR_CTRL_ZERO, rd);
    chk("ctrl0", CTRL0_RST, rd);
    // Length byte first, then random payload
    pl = '{8'h04};
    for (int i = 0; i < 2; i++) pl.push_back(8'($random(seed)));
    foreach (pl[i]) i_host_master.wr(ADDR_TX_QUEUE, {8'h00, pl[i]});
    i_host_master.wr(ADDR_PEEK_PTR, 16'h0000);
    i_host_master.rd(ADDR_PEEK_DATA, rd);
    chk("peek", {8'h00, pl[0]}, rd);
    q = '{8'h00, 8'h00, 8'h00, 8'h00, SYNCWORD_RST[7:0], SYNCWORD_RST[15:8]};
    q = {q, pl};
    channelBusy <= 1'b1;
    start(CMD_IF_CLEAR);
    i_host_master.rd(ADDR_STATUS, rd);
    chk("txBusy", 16'h0000, {15'h0, rd[2]});
    channelBusy <= 1'b0;
    start(CMD_IF_CLEAR);
    fetch(9);
    start(CMD_GO);
    fetch(9);
    // New write flushes; short frame then underflows
    i_host_master.wr(ADDR_TX_QUEUE, 16'h0005);
    q[6] = 8'h05;
    start(CMD_GO);
    fetch(7);
    @(posedge core_clk) modemByteReq <= 1'b1;
    @(posedge core_clk) modemByteReq <= 1'b0;
    i_host_master.wr(ADDR_TX_QUEUE, 16'h0007);
    #1 chk("underflow", 16'h0001, {15'h0, txUnderflowStatus});
    i_host_master.wr(ADDR_COMMAND, 16'h0001 << CMD_FLUSH);
    repeat (2) @(posedge core_clk);
    #1 chk("underflowClr", 16'h0000, {15'h0, txUnderflowStatus});
    i_host_master.wr(ADDR_IO_ZERO, 16'h0005);
    // Reserved-type frame: filter off, filter on, filter on with reserved accept
    fr = '{8'h04, 8'h04, 8'h00, 8'($random(seed)), 8'($random(seed))};
    for (int m = 0; m < 3; m++) begin
      i_host_master.wr(ADDR_CTRL_ZERO, (m == 0) ? 16'h0040 : (m == 1) ? 16'h0041 : 16'h0043);
      rx_frame();
      if (m != 1) rxq = {rxq, fr};
    end
    i_host_master.rd(ADDR_STATUS, rd);
    chk("rxCount", 16'h000a, {8'h00, rd[15:8]});
    chk("threshold", 16'h0001, {15'h0, queueThresholdPin});
    foreach (rxq[i]) begin
      i_host_master.rd(ADDR_RX_QUEUE, rd);
      chk("rxData", {8'h00, rxq[i]}, rd);
    end
    repeat (2) @(posedge core_clk);
    #1 chk("queueHasData", 16'h0000, {15'h0, queueHasData});
    // Serial transmit test mode
    i_host_master.wr(ADDR_CTRL_ONE, 16'h0005);
    start(CMD_GO);
    fetch(6);
    @(posedge serialTxBitValid) #1 chk("serialTxBit", 16'h0001, {15'h0, serialTxBit});
    chk("serialClk", 16'h0001, {15'h0, queueThresholdPin});
    chk("serialDataOe_n", 16'h0001, {15'h0, serialDataOe_n});
    give_verdict();
  end
endmodule
`default_nettype wire
